/* File: rtl/mpwm_defines.vh */
// Purpose: constants for the four-channel pwm core
// Assumes: avalon word addressing, one word per register
// Notes: addresses are word indices; byte address is four times the index
`ifndef MPWM_DEFINES_VH
`define MPWM_DEFINES_VH

`define MPWM_ADR_CLK 6'h00
`define MPWM_ADR_ENA 6'h01
`define MPWM_ADR_SYNC 6'h02
`define MPWM_ADR_STEP 6'h03
`define MPWM_ADR_STAT 6'h04
`define MPWM_ADR_PINS 6'h05
`define MPWM_ADR_OVR 6'h06
`define MPWM_ADR_FLT 6'h07
// channel block: index 0x20 + 4*ch + sub
`define MPWM_CH_BASE 2'b10
`define MPWM_SUB_MODE 2'h0
`define MPWM_SUB_PRD 2'h1
`define MPWM_SUB_DTY 2'h2
`define MPWM_SUB_CNT 2'h3

// clock register fields
`define MPWM_CLK_FAC_A_LSB 0
`define MPWM_CLK_SRC_A_LSB 8
`define MPWM_CLK_FAC_B_LSB 16
`define MPWM_CLK_SRC_B_LSB 24

// channel mode fields
`define MPWM_MODE_PRE_LSB 0
`define MPWM_MODE_ALIGN_BIT 8
`define MPWM_MODE_POL_BIT 9
`define MPWM_MODE_CES_BIT 10
`define MPWM_MODE_TIMER_TRIGGER_SEL_BIT 13

// stepper mode fields
`define MPWM_STEP_GEN_BIT 0
`define MPWM_STEP_DOWN_BIT 16

// clock selector codes
`define MPWM_SEL_LIN_A 4'hB
`define MPWM_SEL_LIN_B 4'hC
`define MPWM_NUM_CLKS 13
`define MPWM_CHAIN_TAPS 11

`define MPWM_RST_WORD 32'h00000000
`define MPWM_RST_HALF 16'h0000
`define MPWM_RST_BYTE 8'h00
`define MPWM_RST_NIB 4'h0

`endif

/* File: rtl/mpwm_clkgen.v */
// Purpose: shared clock generator, produces one-cycle tick enables
// Assumes: everything runs on clk; a tick stands for one edge of a divided clock
// Notes: selector codes 0..10 pick the chain, other codes give no source
`timescale 1ns/1ps
`include "mpwm_defines.vh"
module mpwm_clkgen (
    clk,
    srst,
    src_a_sel,
    src_b_sel,
    fac_a,
    fac_b,
    tick
);
    input wire clk;
    input wire srst;
    input wire [3:0] src_a_sel;
    input wire [3:0] src_b_sel;
    input wire [7:0] fac_a;
    input wire [7:0] fac_b;
    output wire [`MPWM_NUM_CLKS-1:0] tick;

    reg [9:0] chain_r;
    wire [`MPWM_CHAIN_TAPS-1:0] chain_tick;
    reg [7:0] lin_cnt_r [0:1];
    reg [1:0] lin_tick_r;
    wire [3:0] src_sel [0:1];
    wire [7:0] fac [0:1];

    assign src_sel[0] = src_a_sel;
    assign src_sel[1] = src_b_sel;
    assign fac[0] = fac_a;
    assign fac[1] = fac_b;

    always @(posedge clk) begin
        if (srst) begin
            chain_r <= 10'h000;
        end else begin
            chain_r <= chain_r + 10'h001;
        end
    end

    genvar k;
    generate
        for (k = 0; k < `MPWM_CHAIN_TAPS; k = k + 1) begin : g_tap
            if (k == 0) begin : g_full
                assign chain_tick[k] = ~srst;
            end else begin : g_div
                assign chain_tick[k] = ~srst & (&chain_r[k-1:0]);
            end
        end
        for (k = 0; k < 2; k = k + 1) begin : g_lin
            wire src_tick;
            assign src_tick = (src_sel[k] < 4'hB) ? chain_tick[src_sel[k]] : 1'b0;
            always @(posedge clk) begin
                if (srst || fac[k] == 8'h00) begin
                    lin_cnt_r[k] <= `MPWM_RST_BYTE;
                    lin_tick_r[k] <= 1'b0;
                end else if (src_tick) begin
                    if (lin_cnt_r[k] >= fac[k] - 8'h01) begin
                        lin_cnt_r[k] <= 8'h00;
                        lin_tick_r[k] <= 1'b1;
                    end else begin
                        lin_cnt_r[k] <= lin_cnt_r[k] + 8'h01;
                        lin_tick_r[k] <= 1'b0;
                    end
                end else begin
                    lin_tick_r[k] <= 1'b0;
                end
            end
        end
    endgenerate

    assign tick = {lin_tick_r[1], lin_tick_r[0], chain_tick};
endmodule

/* File: rtl/mpwm_core.v */
// Summary of operation
// - clock generator offers thirteen clocks: eleven chain taps, two linear dividers
// - chain taps divide the clock by one up to 1024 in powers of two
// - two linear dividers give linear_clk_a and linear_clk_b, ratio 1 to 255
// - each linear divider divides its chosen chain tap by its factor
// - factors and sources reset to zero; zero factor keeps linear clock stopped
// - during reset all chain taps are stopped, the undivided clock included
// - each channel picks its own counter clock; selector resets to zero
// - each channel has a 16-bit up or up/down counter
// - sync bit makes the comparator use channel 0 counter
// - left aligned: count up to period minus one, restart at zero, period ends
// - centre aligned: up to period, down to zero, period doubled
// - alignment bit per channel, left aligned by default
// - polarity bit sets start level, low by default
// - output fixed 0 for duty=period pol 0 or duty=0 pol 1
// - output fixed 1 for duty=0 pol 0 or duty=period pol 1
// - output holds one level for part of period, opposite for rest
// - counter event at period end; centre with event bit also half period
// - trigger select picks comparator output or counter event for timer
// - pair 0 gray enable drives a 2-bit gray count, direction live
// - output stage: no dead time, override, then fault on enabled channels with top priority
//
// Purpose: four-channel pwm with avalon-mm register slave
// Assumes: inputs synchronous to clk; fault_in already filtered
// Notes: divided clocks are tick enables, so there is one clock domain
`timescale 1ns/1ps
`include "mpwm_defines.vh"
module mpwm_core #(
    parameter NCH = 4
) (
    input wire clk,
    input wire srst,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire [NCH-1:0] fault_in,
    output reg [NCH-1:0] final_out_high,
    output reg [NCH-1:0] final_out_low,
    output reg [NCH-1:0] final_out_high_oe,
    output reg [NCH-1:0] final_out_low_oe,
    output reg [NCH-1:0] timer_trigger
);
    // global registers
    reg [7:0] divider_a_factor_r;
    reg [3:0] divider_a_source_sel_r;
    reg [7:0] divider_b_factor_r;
    reg [3:0] divider_b_source_sel_r;
    reg [NCH-1:0] chan_enable_r;
    reg [NCH-1:0] sync_channel_bit_r;
    reg gray_pair0_enable_r;
    reg gray_down_r;
    reg [NCH-1:0] event_flag_r;
    reg [15:0] override_r;
    reg [15:0] fault_cfg_r;
    reg [1:0] gray_r;

    wire [`MPWM_NUM_CLKS-1:0] tick;
    wire [NCH*16-1:0] cnt_all;
    wire [NCH*16-1:0] mode_all;
    wire [NCH*16-1:0] prd_all;
    wire [NCH*16-1:0] dty_all;
    wire [NCH-1:0] oc_all;
    wire [NCH-1:0] evt_all;
    wire [NCH-1:0] timer_trigger_sel_all;
    wire [NCH-1:0] falling_all;
    wire wr_go;
    wire ch_hit;
    wire [31:0] bmask;
    wire [31:0] wr_word;
    reg [31:0] rd_mux;
    // a request completes on the edge where waitrequest is seen low
    assign wr_go = avs_write & ~avs_waitrequest;
    assign ch_hit = (avs_address[5:4] == `MPWM_CH_BASE);
    assign bmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                    {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
    // rd_mux holds the addressed word, so lanes left off keep their old bytes
    assign wr_word = (rd_mux & ~bmask) | (avs_writedata & bmask);

    mpwm_clkgen u_clkgen (
        .clk(clk),
        .srst(srst),
        .src_a_sel(divider_a_source_sel_r),
        .src_b_sel(divider_b_source_sel_r),
        .fac_a(divider_a_factor_r),
        .fac_b(divider_b_factor_r),
        .tick(tick)
    );

    // one wait state: waitrequest drops the cycle after a request appears
    always @(posedge clk) begin
        if (srst) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= `MPWM_RST_WORD;
        end else if ((avs_read | avs_write) & avs_waitrequest) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= avs_read ? rd_mux : `MPWM_RST_WORD;
        end else begin
            avs_waitrequest <= 1'b1;
        end
    end

    always @* begin
        rd_mux = `MPWM_RST_WORD;
        if (ch_hit) begin
            case (avs_address[1:0])
                `MPWM_SUB_MODE: rd_mux = {16'h0000, mode_all[avs_address[3:2]*16 +: 16]};
                `MPWM_SUB_PRD: rd_mux = {16'h0000, prd_all[avs_address[3:2]*16 +: 16]};
                `MPWM_SUB_DTY: rd_mux = {16'h0000, dty_all[avs_address[3:2]*16 +: 16]};
                default: rd_mux = {16'h0000, cnt_all[avs_address[3:2]*16 +: 16]};
            endcase
        end else begin
            case (avs_address)
                `MPWM_ADR_CLK: rd_mux = {4'h0, divider_b_source_sel_r, divider_b_factor_r,
                                         4'h0, divider_a_source_sel_r, divider_a_factor_r};
                `MPWM_ADR_ENA: rd_mux = {{(32-NCH){1'b0}}, chan_enable_r};
                `MPWM_ADR_SYNC: rd_mux = {{(32-NCH){1'b0}}, sync_channel_bit_r};
                `MPWM_ADR_STEP: rd_mux = {15'h0000, gray_down_r, 15'h0000, gray_pair0_enable_r};
                `MPWM_ADR_STAT: rd_mux = {{(32-NCH){1'b0}}, event_flag_r};
                `MPWM_ADR_PINS: rd_mux = {22'h000000, gray_r,
                                          final_out_low, final_out_high};
                `MPWM_ADR_OVR: rd_mux = {16'h0000, override_r};
                `MPWM_ADR_FLT: rd_mux = {16'h0000, fault_cfg_r};
                default: rd_mux = `MPWM_RST_WORD;
            endcase
        end
    end

    // global register writes
    always @(posedge clk) begin
        if (srst) begin
            divider_a_factor_r <= `MPWM_RST_BYTE;
            divider_a_source_sel_r <= `MPWM_RST_NIB;
            divider_b_factor_r <= `MPWM_RST_BYTE;
            divider_b_source_sel_r <= `MPWM_RST_NIB;
            chan_enable_r <= {NCH{1'b0}};
            sync_channel_bit_r <= {NCH{1'b0}};
            gray_pair0_enable_r <= 1'b0;
            gray_down_r <= 1'b0;
            override_r <= `MPWM_RST_HALF;
            fault_cfg_r <= `MPWM_RST_HALF;
        end else if (wr_go && !ch_hit) begin
            case (avs_address)
                `MPWM_ADR_CLK: begin
                    divider_a_factor_r <= wr_word[`MPWM_CLK_FAC_A_LSB +: 8];
                    divider_a_source_sel_r <= wr_word[`MPWM_CLK_SRC_A_LSB +: 4];
                    divider_b_factor_r <= wr_word[`MPWM_CLK_FAC_B_LSB +: 8];
                    divider_b_source_sel_r <= wr_word[`MPWM_CLK_SRC_B_LSB +: 4];
                end
                `MPWM_ADR_ENA: chan_enable_r <= avs_byteenable[0] ?
                                                avs_writedata[NCH-1:0] : chan_enable_r;
                `MPWM_ADR_SYNC: sync_channel_bit_r <= avs_byteenable[0] ?
                                                      avs_writedata[NCH-1:0] :
                                                      sync_channel_bit_r;
                `MPWM_ADR_STEP: begin
                    // direction may change at any time
                    if (avs_byteenable[0]) begin
                        gray_pair0_enable_r <= avs_writedata[`MPWM_STEP_GEN_BIT];
                    end
                    if (avs_byteenable[2]) begin
                        gray_down_r <= avs_writedata[`MPWM_STEP_DOWN_BIT];
                    end
                end
                `MPWM_ADR_OVR: override_r <= wr_word[15:0];
                `MPWM_ADR_FLT: fault_cfg_r <= wr_word[15:0];
                default: ;
            endcase
        end
    end

    // sticky event flags, write one to clear; a new event beats the clear
    always @(posedge clk) begin
        if (srst) begin
            event_flag_r <= {NCH{1'b0}};
        end else if (wr_go && !ch_hit && avs_address == `MPWM_ADR_STAT &&
                     avs_byteenable[0]) begin
            event_flag_r <= (event_flag_r & ~avs_writedata[NCH-1:0]) | evt_all;
        end else begin
            event_flag_r <= event_flag_r | evt_all;
        end
    end

    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            reg [3:0] channel_prescaler_sel_r;
            reg alignment_sel_r;
            reg start_polarity_r;
            reg centre_event_sel_r;
            reg timer_trigger_sel_r;
            reg [15:0] period_value_r;
            reg [15:0] duty_value_r;
            reg [15:0] cnt_r;
            reg dir_r;
            reg compare_out_r;
            reg evt_r;
            wire wr_me;
            wire clk_tick;
            wire [15:0] cmp_cnt;
            wire cnt_falling;
            wire cmp_falling;

            assign wr_me = wr_go && ch_hit && (avs_address[3:2] == i);
            assign clk_tick = (channel_prescaler_sel_r < 4'hD) ?
                              tick[channel_prescaler_sel_r] : 1'b0;
            assign cmp_cnt = sync_channel_bit_r[i] ? cnt_all[15:0] : cnt_r;
            // top and falling half compare inclusively so both halves span duty ticks
            assign cnt_falling = alignment_sel_r & (dir_r | (cnt_r == period_value_r));
            assign cmp_falling = sync_channel_bit_r[i] ? falling_all[0] : cnt_falling;

            always @(posedge clk) begin
                if (srst) begin
                    channel_prescaler_sel_r <= `MPWM_RST_NIB;
                    alignment_sel_r <= 1'b0;
                    start_polarity_r <= 1'b0;
                    centre_event_sel_r <= 1'b0;
                    timer_trigger_sel_r <= 1'b0;
                    period_value_r <= `MPWM_RST_HALF;
                    duty_value_r <= `MPWM_RST_HALF;
                end else if (wr_me) begin
                    case (avs_address[1:0])
                        `MPWM_SUB_MODE: begin
                            if (avs_byteenable[0]) begin
                                channel_prescaler_sel_r <= avs_writedata[3:0];
                            end
                            if (avs_byteenable[1]) begin
                                alignment_sel_r <= avs_writedata[`MPWM_MODE_ALIGN_BIT];
                                start_polarity_r <= avs_writedata[`MPWM_MODE_POL_BIT];
                                centre_event_sel_r <= avs_writedata[`MPWM_MODE_CES_BIT];
                                timer_trigger_sel_r <= avs_writedata[`MPWM_MODE_TIMER_TRIGGER_SEL_BIT];
                            end
                        end
                        `MPWM_SUB_PRD: period_value_r <= wr_word[15:0];
                        `MPWM_SUB_DTY: duty_value_r <= wr_word[15:0];
                        default: ;
                    endcase
                end
            end

            always @(posedge clk) begin
                if (srst || !chan_enable_r[i]) begin
                    cnt_r <= `MPWM_RST_HALF;
                    dir_r <= 1'b0;
                    evt_r <= 1'b0;
                end else if (!clk_tick) begin
                    evt_r <= 1'b0;
                end else if (!alignment_sel_r) begin
                    if ({1'b0, cnt_r} + 17'h00001 >= {1'b0, period_value_r}) begin
                        cnt_r <= 16'h0000;
                        evt_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                        evt_r <= 1'b0;
                    end
                end else if (!dir_r) begin
                    // turn round at the period value
                    if (cnt_r >= period_value_r) begin
                        dir_r <= (period_value_r != 16'h0000);
                        cnt_r <= (cnt_r == 16'h0000) ? 16'h0000 : cnt_r - 16'h0001;
                        evt_r <= centre_event_sel_r | (period_value_r == 16'h0000);
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                        evt_r <= 1'b0;
                    end
                end else begin
                    if (cnt_r <= 16'h0001) begin
                        cnt_r <= 16'h0000;
                        dir_r <= 1'b0;
                        evt_r <= 1'b1;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                        evt_r <= 1'b0;
                    end
                end
            end

            // polarity level while count below duty
            always @(posedge clk) begin
                if (srst) begin
                    compare_out_r <= 1'b0;
                end else if (!chan_enable_r[i]) begin
                    compare_out_r <= start_polarity_r;
                end else if (cmp_falling ? (cmp_cnt <= duty_value_r) : (cmp_cnt < duty_value_r)) begin
                    compare_out_r <= start_polarity_r;
                end else begin
                    compare_out_r <= ~start_polarity_r;
                end
            end

            assign cnt_all[i*16 +: 16] = cnt_r;
            assign prd_all[i*16 +: 16] = period_value_r;
            assign dty_all[i*16 +: 16] = duty_value_r;
            assign mode_all[i*16 +: 16] = {2'b00, timer_trigger_sel_r, 2'b00,
                                           centre_event_sel_r, start_polarity_r,
                                           alignment_sel_r, 4'h0,
                                           channel_prescaler_sel_r};
            assign oc_all[i] = compare_out_r;
            assign evt_all[i] = evt_r;
            assign timer_trigger_sel_all[i] = timer_trigger_sel_r;
            assign falling_all[i] = cnt_falling;
        end
    endgenerate
    // gray count steps on each channel 0 counter event
    always @(posedge clk) begin
        if (srst || !gray_pair0_enable_r) begin
            gray_r <= 2'b00;
        end else if (evt_all[0]) begin
            // up runs 00 01 11 10, down the same in reverse
            gray_r <= gray_down_r ? {~gray_r[0], gray_r[1]} : {gray_r[0], ~gray_r[1]};
        end
    end
    // output stage, fault last so it wins
    integer n;
    reg [NCH-1:0] wave;
    reg [NCH-1:0] ov_h;
    reg [NCH-1:0] ov_l;
    always @* begin
        wave = oc_all;
        if (gray_pair0_enable_r) begin
            wave[0] = gray_r[0];
            wave[1] = gray_r[1];
        end
        // dead time not fitted: complementary pair with zero delay
        ov_h = wave;
        ov_l = ~wave;
        for (n = 0; n < NCH; n = n + 1) begin
            if (override_r[n]) begin
                ov_h[n] = override_r[8+n];
            end
            if (override_r[4+n]) begin
                ov_l[n] = override_r[12+n];
            end
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            final_out_high <= {NCH{1'b0}};
            final_out_low <= {NCH{1'b0}};
            final_out_high_oe <= {NCH{1'b0}};
            final_out_low_oe <= {NCH{1'b0}};
            timer_trigger <= {NCH{1'b0}};
        end else begin
            for (n = 0; n < NCH; n = n + 1) begin
                final_out_high[n] <= (fault_in[n] & chan_enable_r[n]) ? fault_cfg_r[n] : ov_h[n];
                final_out_low[n] <= (fault_in[n] & chan_enable_r[n]) ? fault_cfg_r[4+n] : ov_l[n];
                final_out_high_oe[n] <= ~(fault_in[n] & chan_enable_r[n] & fault_cfg_r[8+n]);
                final_out_low_oe[n] <= ~(fault_in[n] & chan_enable_r[n] & fault_cfg_r[12+n]);
                timer_trigger[n] <= timer_trigger_sel_all[n] ? evt_all[n] : oc_all[n];
            end
        end
    end
endmodule

/* File: testbench/mpwm_core_asserts.sv */
// Purpose: bus handshake and output stage checks for mpwm_core
// Assumes: override and hi-z fields stay at their reset values
// Notes: bound to every mpwm_core instance
`timescale 1ns/1ps
module mpwm_core_asserts #(
    parameter NCH = 4
) (
    input wire clk,
    input wire srst,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [NCH-1:0] fault_in,
    input wire [NCH-1:0] final_out_high,
    input wire [NCH-1:0] final_out_low,
    input wire [NCH-1:0] final_out_high_oe,
    input wire [NCH-1:0] final_out_low_oe
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    wire rq = avs_read | avs_write;
    wire calm = ~|fault_in;
    AST_TAKE: assert property (rq && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered next cycle");
    AST_ONE_LOW: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low too long");
    AST_NO_CAUSE: assert property (!avs_waitrequest |-> $past(rq))
        else $error("waitrequest low without request");
    AST_BOUND: assert property (rq |-> ##[0:2] !avs_waitrequest)
        else $error("request hangs");
    AST_RD_HOLD: assert property (!$past(srst) && avs_waitrequest && $past(avs_waitrequest)
        |-> $stable(avs_readdata)) else $error("read data moved while idle");
    AST_UNMAP: assert property (avs_read && !avs_waitrequest && avs_address[5:3] != 3'h0
        && avs_address[5:4] != 2'h2 |-> avs_readdata == 32'h00000000)
        else $error("unmapped read not zero");
    AST_COMPL:
    assert property (calm && $past(calm) && $past(calm, 2) && !$past(srst) && !$past(srst, 2)
        |-> final_out_low == ~final_out_high) else $error("outputs not complementary");
    AST_OE_ON:
    assert property (!$past(srst) |-> (&final_out_high_oe) && (&final_out_low_oe))
        else $error("output enable dropped");
endmodule
bind mpwm_core mpwm_core_asserts #(.NCH(NCH)) u_chk (.clk, .srst, .avs_address, .avs_read,
    .avs_write, .avs_readdata, .avs_waitrequest, .fault_in, .final_out_high, .final_out_low,
    .final_out_high_oe, .final_out_low_oe);

/* File: testbench/mpwm_partner.sv */
// Purpose: bridge driver and timer counter model on channel 0
// Assumes: trigger pulses are at least one idle cycle apart
// Notes: counts trigger pulses and on-time cycles between clears
`timescale 1ns/1ps
module mpwm_partner (
    input wire clk,
    input wire clr,
    input wire trig,
    input wire on_lvl,
    input wire [3:0] fault_cmd,
    output logic [3:0] fault_in,
    output logic [15:0] n_trig,
    output logic [15:0] n_on
);
    logic trig_d;
    assign fault_in = fault_cmd;
    always @(posedge clk) begin
        trig_d <= trig;
        if (clr) begin
            n_trig <= 16'h0000;
            n_on <= 16'h0000;
        end else begin
            n_trig <= n_trig + {15'h0000, trig & ~trig_d};
            n_on <= n_on + {15'h0000, on_lvl};
        end
    end
endmodule

/* File: testbench/mpwm_core_test.sv */
// Purpose: self-checking bench for mpwm_core, channel 0 waveforms
// Assumes: period 4 on channel 0, windows are whole periods
// Notes: expectations come from tick counts per window
`timescale 1ns/1ps
module mpwm_core_test;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic clr = 1'b1;
    logic [5:0] avs_address = 6'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic [3:0] fault_cmd = 4'h0;
    logic [31:0] avs_readdata, rdv;
    logic avs_waitrequest;
    logic [3:0] fault_in, final_out_high, final_out_low, final_out_high_oe;
    logic [3:0] final_out_low_oe, timer_trigger;
    logic [15:0] n_trig, n_on;
    int num_errors = 0;
    int checked = 0;
    always #2.5 clk = ~clk;
    mpwm_core DUT (.clk, .srst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .fault_in, .final_out_high,
        .final_out_low, .final_out_high_oe, .final_out_low_oe, .timer_trigger);
    mpwm_partner u_far (.clk, .clr, .trig(timer_trigger[0]), .on_lvl(final_out_high[0]),
        .fault_cmd, .fault_in, .n_trig, .n_on);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic acc(input logic wr, input logic [5:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do @(posedge clk); while (avs_waitrequest !== 1'b0);
        rdv = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic meas(input int n);
        @(posedge clk);
        clr <= 1'b1;
        @(posedge clk);
        clr <= 1'b0;
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic cfg(input logic [31:0] mode, input logic [31:0] ck, input logic [31:0] dty);
        acc(1'b1, 6'h01, 32'h00000000);
        acc(1'b1, 6'h00, ck);
        acc(1'b1, 6'h21, 32'h00000004);
        acc(1'b1, 6'h22, dty);
        acc(1'b1, 6'h20, mode);
        acc(1'b1, 6'h01, 32'h00000001);
        repeat (40) @(posedge clk);
    endtask
    task automatic t_reset;
        acc(1'b0, 6'h00, 32'h00000000);
        chk(rdv, 32'h00000000);
        acc(1'b0, 6'h20, 32'h00000000);
        chk(rdv, 32'h00000000);
        acc(1'b0, 6'h23, 32'h00000000);
        chk(rdv, 32'h00000000);
        acc(1'b1, 6'h10, 32'hFFFFFFFF);
        acc(1'b0, 6'h10, 32'h00000000);
        chk(rdv, 32'h00000000);
        $display("test reset done");
    endtask
    task automatic t_wave;
        for (int p = 0; p < 2; p++) begin
            for (int d = 0; d <= 4; d += 2) begin
                cfg(32'h2000 | (p << 9), 32'h00000000, d);
                meas(40);
                chk({16'h0000, n_on}, p ? d * 10 : (4 - d) * 10);
                chk({16'h0000, n_trig}, 32'h0000000A);
            end
        end
        $display("test wave done");
    endtask
    task automatic t_centre;
        for (int c = 0; c < 2; c++) begin
            cfg(32'h2100 | (c << 10), 32'h00000000, 32'h00000002);
            meas(80);
            chk({16'h0000, n_on}, 32'h00000028);
            chk({16'h0000, n_trig}, (c + 1) * 10);
        end
        $display("test centre done");
    endtask
    task automatic t_clock;
        logic [3:0] pre[5] = '{4'h1, 4'h2, 4'hB, 4'hC, 4'hC};
        logic [31:0] ck[5] = '{0, 0, 32'h00000003, 32'h00000003, 32'h01020000};
        int exp[5] = '{30, 15, 20, 0, 15};
        for (int i = 0; i < 5; i++) begin
            cfg(32'h2000 | pre[i], ck[i], 32'h00000002);
            meas(240);
            chk({16'h0000, n_trig}, exp[i]);
        end
        $display("test clock done");
    endtask
    task automatic t_fault;
        cfg(32'h00000000, 32'h00000000, 32'h00000000);
        fault_cmd <= 4'h1;
        repeat (4) @(posedge clk);
        chk({final_out_high[0], final_out_low[0]}, 32'h00000000);
        fault_cmd <= 4'h0;
        repeat (4) @(posedge clk);
        chk(final_out_high[0], 32'h00000001);
        $display("test fault done");
    endtask
    task automatic t_gray;
        cfg(32'h00002000, 32'h00000000, 32'h00000002);
        acc(1'b1, 6'h03, 32'h00000001);
        meas(160);
        chk({16'h0000, n_on}, 32'h00000050);
        acc(1'b1, 6'h03, 32'h00010001);
        meas(160);
        chk({16'h0000, n_on}, 32'h00000050);
        $display("test gray done");
    endtask
    task report_and_stop;
        $display("checked %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        clr <= 1'b0;
        t_reset;
        t_wave;
        t_centre;
        t_clock;
        t_fault;
        t_gray;
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        report_and_stop;
    end
endmodule
